/* core/mbrr_pkg.sv */
// Constants shared by the read-only Modbus responder
//
// What this block does
// - RTU served only in Modbus serial mode
// - Functions 0x01, 0x03 over addresses 0..0x270E
// - Only own unit address answered, no broadcast
// - Relay n sits at coil address n-1
// - Coil bit one means relay energised
// - Lowest requested relay in reply bit zero
// - Reply echoes unit, function, then byte count
// - RTU: unit, function, start, quantity, CRC
// - TCP: transaction, protocol, length; no CRC
// - TCP protocol identifier is always zero
// - Channel value is 32 bits in two words
// - Overrange reads as 32000 or -32000
// - Channel words at addresses zero to seven
// - Alarm highs at 8..15, 0x8000 when off
// - Alarm lows at 16..23, 0x8000 when off
// - Decimal points start at address 24
// - Register reply high byte first, ascending
package mbrr_pkg;

  // ------------------------------------------------------------
  // Protocol codes and limits
  // ------------------------------------------------------------
  localparam logic [7:0] FN_COIL_READ = 8'h01;
  localparam logic [7:0] FN_HOLD_READ = 8'h03;
  localparam logic [15:0] ADDR_LAST = 16'h270e;
  localparam logic [15:0] MAX_COIL_QTY = 16'h07d0;
  localparam logic [15:0] MAX_REG_QTY = 16'h007d;
  localparam logic [15:0] TCP_PROTO_ID = 16'h0000;
  localparam logic [15:0] TCP_QUERY_LEN = 16'h0006;
  localparam logic [15:0] TCP_LEN_BASE = 16'h0003;
  localparam logic [2:0] SERIAL_FN_MODBUS = 3'h5;

  // ------------------------------------------------------------
  // Frame geometry
  // ------------------------------------------------------------
  localparam int RX_BUF_LEN = 12;
  localparam logic [3:0] RTU_QUERY_BYTES = 4'h8;
  localparam logic [3:0] TCP_QUERY_BYTES = 4'hc;
  localparam logic [8:0] TCP_HEAD_BYTES = 9'h009;
  localparam logic [8:0] RTU_HEAD_BYTES = 9'h003;
  localparam logic [8:0] RTU_HEAD_SKIP = 9'h006;
  localparam logic [8:0] RTU_CRC_BYTES = 9'h002;

  // ------------------------------------------------------------
  // Check sum
  // ------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // ------------------------------------------------------------
  // Holding register map
  // ------------------------------------------------------------
  localparam logic [15:0] REG_CHAN_BASE = 16'h0000;
  localparam logic [15:0] REG_AHI_BASE = 16'h0008;
  localparam logic [15:0] REG_ALO_BASE = 16'h0010;
  localparam logic [15:0] REG_DP_BASE = 16'h0018;
  localparam logic [15:0] REG_MAP_END = 16'h0020;
  localparam logic [15:0] COIL_COUNT = 16'h0008;
  localparam logic [15:0] NO_SETPOINT = 16'h8000;
  localparam logic [31:0] OVER_POS_VAL = 32'h00007d00;
  localparam logic [31:0] OVER_NEG_VAL = 32'hffff8300;

  typedef enum logic {MBRR_COLLECT, MBRR_SEND} mbrr_state_t;

endpackage

/* core/mbrr_responder.sv */
// Modbus coil and holding register read responder, RTU and TCP
`timescale 1ns/1ps
module mbrr_responder
  import mbrr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] unitAddress,
  input wire logic [2:0] serialOperatingFunction,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  input wire logic rxEnd,
  input wire logic rxTcp,
  input wire logic [7:0] relayEnergised,
  input wire logic [127:0] channelValue,
  input wire logic [3:0] chanOverPos,
  input wire logic [3:0] chanOverNeg,
  input wire logic [127:0] alarmHigh,
  input wire logic [7:0] alarmHighOn,
  input wire logic [127:0] alarmLow,
  input wire logic [7:0] alarmLowOn,
  input wire logic [127:0] decimalPoint,
  output logic [7:0] txByte,
  output logic txValid,
  output logic txLast,
  input wire logic txReady,
  output logic rxBusy
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // One byte of the reflected 0xA001 check sum
  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Channel word pair with overrange substitution
  function automatic logic [31:0] chanVal(input logic [1:0] ch);
    logic [31:0] v;
    v = channelValue[32*ch +: 32];
    if (chanOverPos[ch]) begin
      v = OVER_POS_VAL;
    end else if (chanOverNeg[ch]) begin
      v = OVER_NEG_VAL;
    end
    return v;
  endfunction

  // Holding register contents; unmapped addresses read zero
  function automatic logic [15:0] regWord(input logic [15:0] a);
    logic [15:0] w;
    logic [31:0] cv;
    logic [2:0] n;
    w = 16'h0000;
    n = a[2:0];
    cv = chanVal(a[2:1]);
    if (a < REG_AHI_BASE) begin
      w = a[0] ? cv[15:0] : cv[31:16];
    end else if (a < REG_ALO_BASE) begin
      w = alarmHighOn[n] ? alarmHigh[16*n +: 16] : NO_SETPOINT;
    end else if (a < REG_DP_BASE) begin
      w = alarmLowOn[n] ? alarmLow[16*n +: 16] : NO_SETPOINT;
    end else if (a < REG_MAP_END) begin
      w = decimalPoint[16*n +: 16];
    end
    return w;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  mbrr_state_t state_q, state_d;
  logic [7:0] buf_q [RX_BUF_LEN];
  logic [7:0] buf_d [RX_BUF_LEN];
  logic [3:0] rxCnt_q, rxCnt_d;
  logic rxOver_q, rxOver_d;
  logic [15:0] rxCrc_q, rxCrc_d;
  logic [15:0] txCrc_q, txCrc_d;
  logic [15:0] tid_q, tid_d;
  logic [7:0] fn_q, fn_d;
  logic [15:0] start_q, start_d;
  logic [15:0] qty_q, qty_d;
  logic [7:0] bc_q, bc_d;
  logic tcp_q, tcp_d;
  logic [8:0] idx_q, idx_d;
  logic [7:0] txByte_q, txByte_d;
  logic txValid_q, txValid_d;

  // Decoded query fields from the receive buffer
  logic [3:0] off;
  logic [7:0] qUnit, qFn;
  logic [15:0] qStart, qQty, qLen, qProto;
  logic [16:0] qEnd;
  logic frameOk, fnOk, rangeOk, accept;
  logic [8:0] dataEnd, total, nxtIdx, headIdx, pos;
  logic [7:0] nxtByte;
  logic [15:0] regAddr, coilAddr, rspLen;
  logic [15:0] rdWord;
  logic txAccept;

  assign txAccept = txValid_q && txReady;
  assign off = rxTcp ? 4'h6 : 4'h0;

  // ------------------------------------------------------------
  // Query decode
  // ------------------------------------------------------------
  // Both framings share the PDU layout, offset by the TCP prefix
  always_comb begin
    qUnit = buf_q[off];
    qFn = buf_q[off + 4'h1];
    qStart = {buf_q[off + 4'h2], buf_q[off + 4'h3]};
    qQty = {buf_q[off + 4'h4], buf_q[off + 4'h5]};
    qProto = {buf_q[2], buf_q[3]};
    qLen = {buf_q[4], buf_q[5]};
    qEnd = {1'b0, qStart} + {1'b0, qQty};
    if (rxTcp) begin
      frameOk = !rxOver_q && rxCnt_q == TCP_QUERY_BYTES
        && qProto == TCP_PROTO_ID
        && qLen == TCP_QUERY_LEN;
    end else begin
      // RTU only in Modbus mode; residue of a good CRC is zero
      frameOk = !rxOver_q && rxCnt_q == RTU_QUERY_BYTES
        && serialOperatingFunction == SERIAL_FN_MODBUS
        && rxCrc_q == 16'h0000;
    end
    fnOk = qFn == FN_COIL_READ || qFn == FN_HOLD_READ;
    rangeOk = qQty != 16'h0000
      && qQty <= (qFn == FN_COIL_READ ? MAX_COIL_QTY : MAX_REG_QTY)
      && qEnd <= {1'b0, ADDR_LAST} + 17'h00001;
    // Broadcast never matches: only our own unit is answered
    accept = frameOk && fnOk && rangeOk
      && qUnit == unitAddress;
  end

  // ------------------------------------------------------------
  // Reply byte generator
  // ------------------------------------------------------------
  // Next byte is prepared one cycle ahead so txByte is a flop
  always_comb begin
    nxtIdx = (state_q == MBRR_SEND) ? idx_q + 9'h001 : 9'h000;
    dataEnd = (tcp_d ? TCP_HEAD_BYTES : RTU_HEAD_BYTES) + {1'b0, bc_d};
    total = dataEnd + (tcp_d ? 9'h000 : RTU_CRC_BYTES);
    headIdx = tcp_d ? nxtIdx : nxtIdx + RTU_HEAD_SKIP;
    pos = nxtIdx - (tcp_d ? TCP_HEAD_BYTES : RTU_HEAD_BYTES);
    rspLen = TCP_LEN_BASE + {8'h00, bc_d};
    regAddr = start_d + {8'h00, pos[8:1]};
    // Word fetched once; a select on a call result is not portable
    rdWord = regWord(regAddr);
    coilAddr = start_d + {4'h0, pos, 3'h0};
    nxtByte = 8'h00;
    if (nxtIdx >= dataEnd) begin
      // Check sum goes low byte first, RTU only
      nxtByte = (nxtIdx == dataEnd) ? txCrc_d[7:0] : txCrc_d[15:8];
    end else if (headIdx < TCP_HEAD_BYTES) begin
      case (headIdx[3:0])
        4'h0: nxtByte = tid_d[15:8];
        4'h1: nxtByte = tid_d[7:0];
        4'h2: nxtByte = TCP_PROTO_ID[15:8];
        4'h3: nxtByte = TCP_PROTO_ID[7:0];
        4'h4: nxtByte = rspLen[15:8];
        4'h5: nxtByte = rspLen[7:0];
        4'h6: nxtByte = unitAddress;
        4'h7: nxtByte = fn_d;
        4'h8: nxtByte = bc_d;
        default: nxtByte = 8'h00;
      endcase
    end else if (fn_d == FN_COIL_READ) begin
      for (int j = 0; j < 8; j++) begin
        // Coil address n is relay n+1; bits past quantity are zero
        if ({1'b0, coilAddr} + 17'(j) < {1'b0, start_d} + {1'b0, qty_d}
            && coilAddr + 16'(j) < COIL_COUNT) begin
          nxtByte[j] = relayEnergised[3'(coilAddr + 16'(j))];
        end
      end
    end else begin
      nxtByte = pos[0] ? rdWord[7:0] : rdWord[15:8];
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    buf_d = buf_q;
    rxCnt_d = rxCnt_q;
    rxOver_d = rxOver_q;
    rxCrc_d = rxCrc_q;
    txCrc_d = txCrc_q;
    tid_d = tid_q;
    fn_d = fn_q;
    start_d = start_q;
    qty_d = qty_q;
    bc_d = bc_q;
    tcp_d = tcp_q;
    idx_d = idx_q;
    txByte_d = txByte_q;
    txValid_d = txValid_q;
    case (state_q)
      MBRR_COLLECT: begin
        if (rxEnd) begin
          // Any frame end restarts collection; bad frames leave no trace
          rxCnt_d = 4'h0;
          rxOver_d = 1'b0;
          rxCrc_d = CRC_INIT;
          if (accept) begin
            tcp_d = rxTcp;
            tid_d = {buf_q[0], buf_q[1]};
            fn_d = qFn;
            start_d = qStart;
            qty_d = qQty;
            bc_d = (qFn == FN_COIL_READ) ? 8'((qQty + 16'h0007) >> 3)
                                         : 8'({qQty, 1'b0});
            txCrc_d = CRC_INIT;
            state_d = MBRR_SEND;
            idx_d = 9'h000;
            txByte_d = nxtByte;
            txValid_d = 1'b1;
          end
        end else if (rxValid) begin
          if (rxCnt_q == 4'(RX_BUF_LEN)) begin
            rxOver_d = 1'b1; // Too long for any query
          end else begin
            buf_d[rxCnt_q] = rxByte;
            rxCnt_d = rxCnt_q + 4'h1;
          end
          rxCrc_d = crcStep(rxCrc_q, rxByte);
        end
      end
      MBRR_SEND: begin
        if (txAccept) begin
          if (idx_q < dataEnd) begin
            txCrc_d = crcStep(txCrc_q, txByte_q);
          end
          if (idx_q + 9'h001 == total) begin
            state_d = MBRR_COLLECT;
            txValid_d = 1'b0;
          end else begin
            idx_d = idx_q + 9'h001;
            txByte_d = nxtByte;
          end
        end
      end
      default: state_d = MBRR_COLLECT;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= MBRR_COLLECT;
      for (int i = 0; i < RX_BUF_LEN; i++) begin
        buf_q[i] <= 8'h00;
      end
      rxCnt_q <= 4'h0;
      rxOver_q <= 1'b0;
      rxCrc_q <= CRC_INIT;
      txCrc_q <= CRC_INIT;
      tid_q <= 16'h0000;
      fn_q <= 8'h00;
      start_q <= 16'h0000;
      qty_q <= 16'h0000;
      bc_q <= 8'h00;
      tcp_q <= 1'b0;
      idx_q <= 9'h000;
      txByte_q <= 8'h00;
      txValid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      buf_q <= buf_d;
      rxCnt_q <= rxCnt_d;
      rxOver_q <= rxOver_d;
      rxCrc_q <= rxCrc_d;
      txCrc_q <= txCrc_d;
      tid_q <= tid_d;
      fn_q <= fn_d;
      start_q <= start_d;
      qty_q <= qty_d;
      bc_q <= bc_d;
      tcp_q <= tcp_d;
      idx_q <= idx_d;
      txByte_q <= txByte_d;
      txValid_q <= txValid_d;
    end
  end

  // Input is ignored while a reply is in flight; rxBusy warns
  assign rxBusy = state_q == MBRR_SEND;
  assign txByte = txByte_q;
  assign txValid = txValid_q;
  assign txLast = txValid_q && (idx_q + 9'h001 == total);

endmodule

/* bench/mbrr_asserts.sv */
// Port checks for the Modbus read responder
`timescale 1ns/1ps
module mbrr_asserts
  import mbrr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] unitAddress,
  input wire logic [2:0] serialOperatingFunction,
  input wire logic rxEnd,
  input wire logic rxTcp,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic txLast,
  input wire logic txReady,
  input wire logic rxBusy
);
  // ----------------------------------------------------------
  // Reply stream timing
  // ----------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_hold;
    txValid && !txReady |=> txValid && $stable(txByte);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte moved");
  property p_first;
    rxEnd && !rxBusy && !rxTcp ##1 txValid |-> txByte == unitAddress;
  endproperty
  a_first: assert property (p_first) else $error("bad unit echo");
  property p_answer;
    $rose(txValid) |-> $past(rxEnd);
  endproperty
  a_answer: assert property (p_answer) else $error("late reply");
  property p_mode;
    rxEnd && !rxBusy && !rxTcp && serialOperatingFunction !=
      SERIAL_FN_MODBUS |=> !txValid;
  endproperty
  a_mode: assert property (p_mode) else $error("RTU off mode");
  property p_quiet;
    !rxBusy && !rxEnd |=> !txValid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("unasked reply");
  property p_release;
    txValid && txReady && txLast |=> !txValid && !rxBusy;
  endproperty
  a_release: assert property (p_release) else $error("no end");
  property p_short;
    $rose(txValid) |-> !txLast ##1 (!txLast || !txValid);
  endproperty
  a_short: assert property (p_short) else $error("reply short");
  property p_busy;
    txValid |-> rxBusy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low");
  // Main scenarios reached
  c_stall: cover property (txValid && !txReady);
  c_tcp: cover property (rxEnd && !rxBusy && rxTcp);
  c_end: cover property (txValid && txReady && txLast);
endmodule

bind mbrr_responder mbrr_asserts u_chk(.core_clk, .rst_b, .unitAddress,
  .serialOperatingFunction, .rxEnd, .rxTcp, .txByte, .txValid, .txLast,
  .txReady, .rxBusy);

/* bench/mbrr_master_model.sv */
// Modbus master model: sends queries, collects reply bytes
`timescale 1ns/1ps
module mbrr_master_model (
  input wire logic core_clk,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic rxEnd,
  output logic rxTcp,
  output logic txReady,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic txLast
);
  logic [7:0] reply[$];
  logic slow = 1'b0;
  logic badCrc = 1'b0;
  logic got = 1'b0;
  logic [15:0] tid = 16'h0000;
  // Protocol id sent in the TCP prefix; non-zero only to test refusal
  logic [15:0] proto = 16'h0000;
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    rxEnd = 1'b0;
    rxTcp = 1'b0;
    txReady = 1'b1;
  end
  // Check field over the whole frame, low byte sent first
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // One query, one byte a cycle; rate is abstract, no baud here
  task automatic send(input logic [7:0] q[$], input logic tcp);
    logic [15:0] c;
    reply.delete();
    got = 1'b0;
    if (tcp) begin
      tid = tid + 16'h0001; // New id per request
      q = {tid[15:8], tid[7:0], proto[15:8], proto[7:0], 8'h00, 8'h06,
        q};
    end else begin
      c = crc16(q);
      if (badCrc) c = ~c;
      q.push_back(c[7:0]); // CRC trails the frame
      q.push_back(c[15:8]);
    end
    foreach (q[i]) begin
      @(posedge core_clk);
      #1;
      rxByte = q[i];
      rxValid = 1'b1;
    end
    @(posedge core_clk);
    #1;
    rxValid = 1'b0;
    rxByte = ~rxByte; // Stale byte is never left on the line
    rxEnd = 1'b1;
    rxTcp = tcp;
    @(posedge core_clk);
    #1;
    rxEnd = 0;
  endtask
  // Slow mode stalls every other cycle to test holding
  always @(posedge core_clk) #1 txReady = slow ? ~txReady : 1'b1;
  // Gather accepted reply bytes
  always @(posedge core_clk) begin
    if (txValid && txReady) begin
      reply.push_back(txByte);
      if (txLast) got = 1'b1;
    end
  end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the Modbus read responder
`timescale 1ns/1ps
module tb_top;
  import mbrr_pkg::*;
  logic core_clk, rst_b, rxValid, rxEnd, rxTcp, txValid, txLast, txReady;
  logic rxBusy;
  logic [7:0] unitAddress = 8'h02, relayEnergised = 8'hb6;
  logic [7:0] rxByte, txByte, alarmHighOn = 8'h5a, alarmLowOn = 8'ha5;
  logic [2:0] serialOperatingFunction = 3'h5;
  logic [3:0] chanOverPos = 4'h1, chanOverNeg = 4'h3;
  logic [127:0] channelValue, alarmHigh, alarmLow, decimalPoint;
  int fails = 0;
  int testsRun = 0;
  mbrr_responder u_dut(.core_clk, .rst_b, .unitAddress,
    .serialOperatingFunction, .rxByte, .rxValid, .rxEnd, .rxTcp,
    .relayEnergised, .channelValue, .chanOverPos, .chanOverNeg, .alarmHigh,
    .alarmHighOn, .alarmLow, .alarmLowOn, .decimalPoint, .txByte, .txValid,
    .txLast, .txReady, .rxBusy);
  mbrr_master_model u_master(.core_clk, .rxByte, .rxValid, .rxEnd, .rxTcp,
    .txReady, .txByte, .txValid, .txLast);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict;
    $display("fails=%0d testsRun=%0d", fails, testsRun);
    if (fails == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Expected word at a holding address
  function automatic logic [15:0] regv(input int a);
    logic [31:0] cv;
    if (a < 8) begin
      cv = channelValue[32*(a/2) +: 32];
      if (chanOverPos[a/2]) cv = 32'h00007d00; // +32000
      else if (chanOverNeg[a/2]) cv = 32'hffff8300; // -32000
      return (a % 2) ? cv[15:0] : cv[31:16];
    end
    if (a < 16) return alarmHighOn[a-8] ? alarmHigh[16*(a-8) +: 16] : 16'h8000;
    if (a < 24) return alarmLowOn[a-16] ? alarmLow[16*(a-16) +: 16] : 16'h8000;
    if (a < 32) return decimalPoint[16*(a-24) +: 16];
    return 16'h0000;
  endfunction
  // One query and its reply, or its silence when ok is low
  task automatic query(input logic tcp, input logic [7:0] unit, fn,
      input logic [15:0] st, qty, input logic ok);
    logic [7:0] e[$];
    logic [7:0] b;
    logic [15:0] w;
    int k, bc;
    e = {unit, fn, st[15:8], st[7:0], qty[15:8], qty[7:0]};
    u_master.send(e, tcp);
    for (k = 0; k < 300 && !u_master.got; k++) @(posedge core_clk);
    e.delete();
    if (ok && fn == 8'h01) begin
      bc = (qty + 7) / 8;
      e = {unit, fn, 8'(bc)};
      for (int i = 0; i < bc; i++) begin
        b = 8'h00;
        for (int j = 0; j < 8; j++) begin
          k = st + i * 8 + j;
          if (i * 8 + j < qty) b[j] = (k < 8) ? relayEnergised[k] : 1'b0;
        end
        e.push_back(b);
      end
    end else if (ok) begin
      e = {unit, fn, 8'(qty * 2)};
      for (int i = 0; i < qty; i++) begin
        w = regv(st + i);
        e.push_back(w[15:8]);
        e.push_back(w[7:0]);
      end
    end
    if (ok && tcp)
      e = {u_master.tid[15:8], u_master.tid[7:0], 8'h00, 8'h00, 8'h00,
        8'(e.size()), e};
    else if (ok) begin
      w = u_master.crc16(e);
      e.push_back(w[7:0]);
      e.push_back(w[15:8]);
    end
    check(16'(u_master.reply.size()), 16'(e.size()));
    foreach (e[i]) check({8'h00, u_master.reply[i]}, {8'h00, e[i]});
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Watchdog against a hung reply
  initial begin
    #(40 * 20000);
    fails++;
    giveVerdict();
  end
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    channelValue = {32'hfffe1234, 32'h00020025, 32'h00000051, 32'h11223344};
    for (int n = 0; n < 8; n++) begin
      alarmHigh[16*n +: 16] = 16'h1000 + 16'(n);
      alarmLow[16*n +: 16] = 16'h2000 + 16'(n);
      decimalPoint[16*n +: 16] = 16'h0030 + 16'(n);
    end
    rst_b = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 rst_b = 1'b1;
    query(0, 8'h02, 8'h01, 16'h0000, 16'h0008, 1);
    query(1, 8'h02, 8'h01, 16'h0000, 16'h0008, 1);
    query(0, 8'h02, 8'h01, 16'h0001, 16'h0003, 1);
    u_master.slow = 1'b1;
    query(1, 8'h02, 8'h03, 16'h0000, 16'h0008, 1);
    query(0, 8'h02, 8'h03, 16'h0008, 16'h0018, 1);
    u_master.slow = 1'b0;
    query(1, 8'h02, 8'h03, 16'h270e, 16'h0001, 1);
    query(1, 8'h02, 8'h01, 16'h270e, 16'h0002, 0);
    query(0, 8'h00, 8'h01, 16'h0000, 16'h0008, 0);
    query(0, 8'h07, 8'h03, 16'h0000, 16'h0001, 0);
    query(1, 8'h02, 8'h02, 16'h0000, 16'h0008, 0);
    u_master.badCrc = 1'b1;
    query(0, 8'h02, 8'h03, 16'h0000, 16'h0001, 0);
    u_master.badCrc = 1'b0;
    u_master.proto = 16'h0001;
    query(1, 8'h02, 8'h03, 16'h0000, 16'h0001, 0);
    u_master.proto = 16'h0000;
    query(0, 8'h02, 8'h03, 16'h0000, 16'h0000, 0);
    query(1, 8'h02, 8'h03, 16'h0000, 16'h007e, 0);
    #1 serialOperatingFunction = 3'h4;
    query(0, 8'h02, 8'h01, 16'h0000, 16'h0008, 0);
    query(1, 8'h02, 8'h01, 16'h0000, 16'h0008, 1);
    giveVerdict();
  end
endmodule
